// file: src/dspcfg_pkg.sv
// Purpose: shared constants and helpers for the transmit path configuration bank
// Assumes: byte-wide register port behind the serial control port
// Notes:   all offsets are byte addresses of the control port
package dspcfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_TX_CONFIG      = 8'h60;
  localparam logic [7:0] ADDR_OSC_FREQ_B0    = 8'h64;
  localparam logic [7:0] ADDR_OSC_FREQ_B1    = 8'h65;
  localparam logic [7:0] ADDR_OSC_FREQ_B2    = 8'h66;
  localparam logic [7:0] ADDR_OSC_FREQ_B3    = 8'h67;
  localparam logic [7:0] ADDR_OSC_FREQ_B4    = 8'h68;
  localparam logic [7:0] ADDR_PHASE_FIX_LOW  = 8'h69;
  localparam logic [7:0] ADDR_PHASE_FIX_HIGH = 8'h6a;
  localparam logic [7:0] ADDR_CHAN_A_GAIN_LO = 8'h6b;
  localparam logic [7:0] ADDR_CHAN_A_GAIN_HI = 8'h6c;
  localparam logic [7:0] ADDR_CHAN_B_GAIN_LO = 8'h6d;
  localparam logic [7:0] ADDR_CHAN_B_GAIN_HI = 8'h6e;
  localparam logic [7:0] ADDR_OUTPUT_CTRL    = 8'h6f;
  localparam logic [7:0] ADDR_LEVEL_DETECT   = 8'h70;
  localparam logic [7:0] ADDR_CHAN_A_OFS_LO  = 8'h71;
  localparam logic [7:0] ADDR_CHAN_A_OFS_HI  = 8'h72;
  localparam logic [7:0] ADDR_CHAN_B_OFS_LO  = 8'h73;
  localparam logic [7:0] ADDR_CHAN_B_OFS_HI  = 8'h74;
  localparam logic [7:0] ADDR_INPUT_FORMAT   = 8'h75;
  localparam logic [7:0] ADDR_I_CONST_LO     = 8'h76;
  localparam logic [7:0] ADDR_I_CONST_HI     = 8'h77;
  localparam logic [7:0] ADDR_Q_CONST_LO     = 8'h78;
  localparam logic [7:0] ADDR_Q_CONST_HI     = 8'h79;

  // field positions
  localparam int OSC_ENABLE_BIT       = 7;
  localparam int PHASE_FIX_ENABLE_BIT = 7;
  localparam int CHAN_A_GAIN_EN_BIT   = 3;
  localparam int CHAN_B_GAIN_EN_BIT   = 2;
  localparam int FIXED_ATTEN_BIT      = 1;
  localparam int LEVEL_DETECT_EN_BIT  = 0;
  localparam int INPUT_FORMAT_BIT     = 7;
  localparam int I_SEL_LSB            = 2;
  localparam int Q_SEL_LSB            = 0;

  // reset values
  localparam logic [7:0]  RST_INPUT_FORMAT = 8'h85;
  localparam logic [15:0] RST_I_CONST      = 16'h8000;
  localparam logic [15:0] RST_Q_CONST      = 16'h8000;
  localparam logic [11:0] GAIN_UNITY       = 12'h0800; // gain code treated as unity

  // source selection of one sample path
  typedef enum logic [1:0] {
    SRC_LANE      = 2'b00,
    SRC_UNTIL_ILA = 2'b01,
    SRC_CONST_A   = 2'b10,
    SRC_CONST_B   = 2'b11
  } dspcfg_src_t;

  // unsigned words become two's complement by flipping the sign bit
  function automatic logic [15:0] dspcfg_to_twos(input logic [15:0] word, input logic unsigned_fmt);
    dspcfg_to_twos = unsigned_fmt ? {~word[15], word[14:0]} : word;
  endfunction

  // unity unless the channel's gain is switched on
  function automatic logic [11:0] dspcfg_gain_eff(input logic [11:0] gain, input logic enable);
    dspcfg_gain_eff = enable ? gain : GAIN_UNITY;
  endfunction

endpackage

// file: src/dspcfg_path_src.sv
// Purpose: picks the sample fed to processing for one of the I or Q paths
// Assumes: lane samples arrive one per clock, synchronous to core_clk
// Notes:   output is registered, one cycle after the inputs
module dspcfg_path_src
  import dspcfg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // control
  input  wire logic [1:0]  source_sel,
  input  wire logic        ila_done,
  input  wire logic        unsigned_fmt,
  input  wire logic [15:0] constant_level,
  // samples
  input  wire logic [15:0] lane_sample,
  output logic      [15:0] path_sample
);

  typedef struct packed {
    logic [15:0] sample;
  } dspcfg_src_state_t;

  dspcfg_src_state_t state;
  dspcfg_src_state_t next_state;

  // choose lane data or the programmed constant
  always_comb begin
    next_state = state;
    unique case (dspcfg_src_t'(source_sel))
      SRC_LANE:      next_state.sample = dspcfg_to_twos(lane_sample, unsigned_fmt);
      SRC_UNTIL_ILA: next_state.sample = ila_done ? dspcfg_to_twos(lane_sample, unsigned_fmt)
                                                  : constant_level;
      SRC_CONST_A,
      SRC_CONST_B:   next_state.sample = constant_level;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign path_sample = state.sample;

endmodule // dspcfg_path_src

// file: src/dspcfg_regs.sv
// Purpose: configuration bank of the transmit signal path with oscillator and source select
// Assumes: byte register port driven by the serial control port, synchronous to core_clk
// Notes:   read data appears one clock after the read strobe
//
// Notes on behaviour
// - frequency word is 40 bits over five byte registers, low byte first
// - phase correction is 13 bits: low byte, then five bits of the next
// - bit 7 of upper phase register enables phase correction, zero bypasses
// - channel A gain is 12 bits: low byte plus four upper bits
// - channel B gain is 12 bits laid out like channel A
// - output control bit 3 enables A gain, bit 2 enables B gain
// - output control bit 1 selects fixed 3 dB attenuation
// - output control bit 0 switches the level detector on
// - an 8-bit read-write level detector value register
// - channel A offset: low byte first, upper bits at next address
// - channel B offset: low byte first, upper bits at next address
// - format bit 7 selects two's complement at zero, unsigned at one
// - I select: 00 lanes, 01 constant until alignment done, 1x constant
// - Q select in bits 1:0 behaves like I with the Q constant
// - I and Q constants are 16 bits in low and high byte registers
// - clearing oscillator enable stops it and forces the phase to zero
module dspcfg_regs
  import dspcfg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // lane side
  input  wire logic [15:0] lane_i_sample,
  input  wire logic [15:0] lane_q_sample,
  input  wire logic        ila_done,
  // samples to processing
  output logic      [15:0] i_sample,
  output logic      [15:0] q_sample,
  // oscillator
  output logic      [39:0] osc_phase,
  // settings to the processing chain
  output logic      [12:0] phase_fix_factor,
  output logic             phase_fix_enable,
  output logic      [11:0] chan_a_gain_eff,
  output logic      [11:0] chan_b_gain_eff,
  output logic             fixed_attenuate,
  output logic             level_detect_enable,
  output logic      [7:0]  level_detect_value,
  output logic      [15:0] chan_a_offset,
  output logic      [15:0] chan_b_offset,
  output logic             input_word_format
);

  typedef struct packed {
    // oscillator
    logic        osc_enable;
    logic [39:0] osc_freq_word;
    logic [39:0] osc_phase;

    // output phase correction
    logic [12:0] phase_fix_factor;
    logic        phase_fix_enable;

    // stored gains and their enables
    logic [11:0] chan_a_gain;
    logic [11:0] chan_b_gain;
    logic        chan_a_gain_enable;
    logic        chan_b_gain_enable;

    // gains as the processing chain sees them
    logic [11:0] chan_a_gain_eff;
    logic [11:0] chan_b_gain_eff;

    // output control and level detector
    logic        fixed_attenuate;
    logic        level_detect_enable;
    logic [7:0]  level_detect_value;

    // digital offsets
    logic [15:0] chan_a_offset;
    logic [15:0] chan_b_offset;

    // input coding and path sources
    logic        input_word_format;
    logic [1:0]  i_path_source_sel;
    logic [1:0]  q_path_source_sel;

    // constant substitution levels
    logic [15:0] i_constant_level;
    logic [15:0] q_constant_level;

    // read port
    logic [7:0]  rdata;
    logic        rvalid;
  } dspcfg_state_t;

  // current and next value of every flip-flop
  dspcfg_state_t state;
  dspcfg_state_t next_state;

  // register writes, reads and the oscillator
  always_comb begin
    next_state = state;
    // a write lands at the edge that samples the strobe
    if (reg_wr) begin
      unique case (reg_addr)
        // oscillator enable
        ADDR_TX_CONFIG:      next_state.osc_enable = reg_wdata[OSC_ENABLE_BIT];

        // frequency word, one byte per address
        ADDR_OSC_FREQ_B0:    next_state.osc_freq_word[7:0]   = reg_wdata;
        ADDR_OSC_FREQ_B1:    next_state.osc_freq_word[15:8]  = reg_wdata;
        ADDR_OSC_FREQ_B2:    next_state.osc_freq_word[23:16] = reg_wdata;
        ADDR_OSC_FREQ_B3:    next_state.osc_freq_word[31:24] = reg_wdata;
        ADDR_OSC_FREQ_B4:    next_state.osc_freq_word[39:32] = reg_wdata;

        // phase correction factor and its enable
        ADDR_PHASE_FIX_LOW:  next_state.phase_fix_factor[7:0] = reg_wdata;
        ADDR_PHASE_FIX_HIGH: begin
          next_state.phase_fix_factor[12:8] = reg_wdata[4:0];
          next_state.phase_fix_enable       = reg_wdata[PHASE_FIX_ENABLE_BIT];
        end

        // channel A gain
        ADDR_CHAN_A_GAIN_LO: next_state.chan_a_gain[7:0]  = reg_wdata;
        ADDR_CHAN_A_GAIN_HI: next_state.chan_a_gain[11:8] = reg_wdata[3:0];

        // channel B gain
        ADDR_CHAN_B_GAIN_LO: next_state.chan_b_gain[7:0]  = reg_wdata;
        ADDR_CHAN_B_GAIN_HI: next_state.chan_b_gain[11:8] = reg_wdata[3:0];

        // gain enables, attenuation and detector switch
        ADDR_OUTPUT_CTRL: begin
          next_state.chan_a_gain_enable  = reg_wdata[CHAN_A_GAIN_EN_BIT];
          next_state.chan_b_gain_enable  = reg_wdata[CHAN_B_GAIN_EN_BIT];
          next_state.fixed_attenuate     = reg_wdata[FIXED_ATTEN_BIT];
          next_state.level_detect_enable = reg_wdata[LEVEL_DETECT_EN_BIT];
        end

        // level detector value
        ADDR_LEVEL_DETECT:   next_state.level_detect_value = reg_wdata;

        // channel A offset
        ADDR_CHAN_A_OFS_LO:  next_state.chan_a_offset[7:0]  = reg_wdata;
        ADDR_CHAN_A_OFS_HI:  next_state.chan_a_offset[15:8] = reg_wdata;

        // channel B offset
        ADDR_CHAN_B_OFS_LO:  next_state.chan_b_offset[7:0]  = reg_wdata;
        ADDR_CHAN_B_OFS_HI:  next_state.chan_b_offset[15:8] = reg_wdata;

        // input coding and both source selects
        ADDR_INPUT_FORMAT: begin
          next_state.input_word_format = reg_wdata[INPUT_FORMAT_BIT];
          next_state.i_path_source_sel = reg_wdata[I_SEL_LSB+1:I_SEL_LSB];
          next_state.q_path_source_sel = reg_wdata[Q_SEL_LSB+1:Q_SEL_LSB];
        end

        // constant level of the I path
        ADDR_I_CONST_LO:     next_state.i_constant_level[7:0]  = reg_wdata;
        ADDR_I_CONST_HI:     next_state.i_constant_level[15:8] = reg_wdata;

        // constant level of the Q path
        ADDR_Q_CONST_LO:     next_state.q_constant_level[7:0]  = reg_wdata;
        ADDR_Q_CONST_HI:     next_state.q_constant_level[15:8] = reg_wdata;

        // unmapped addresses are ignored
        default: ;
      endcase
    end

    // read data, registered; unmapped addresses and spare bits read zero
    next_state.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        // oscillator enable, other bits spare
        ADDR_TX_CONFIG:      next_state.rdata = {state.osc_enable, 7'h00};

        // frequency word bytes
        ADDR_OSC_FREQ_B0:    next_state.rdata = state.osc_freq_word[7:0];
        ADDR_OSC_FREQ_B1:    next_state.rdata = state.osc_freq_word[15:8];
        ADDR_OSC_FREQ_B2:    next_state.rdata = state.osc_freq_word[23:16];
        ADDR_OSC_FREQ_B3:    next_state.rdata = state.osc_freq_word[31:24];
        ADDR_OSC_FREQ_B4:    next_state.rdata = state.osc_freq_word[39:32];

        // phase correction factor and enable
        ADDR_PHASE_FIX_LOW:  next_state.rdata = state.phase_fix_factor[7:0];
        ADDR_PHASE_FIX_HIGH: next_state.rdata = {state.phase_fix_enable, 2'b00, state.phase_fix_factor[12:8]};

        // channel A gain, upper nibble spare
        ADDR_CHAN_A_GAIN_LO: next_state.rdata = state.chan_a_gain[7:0];
        ADDR_CHAN_A_GAIN_HI: next_state.rdata = {4'h0, state.chan_a_gain[11:8]};

        // channel B gain, upper nibble spare
        ADDR_CHAN_B_GAIN_LO: next_state.rdata = state.chan_b_gain[7:0];
        ADDR_CHAN_B_GAIN_HI: next_state.rdata = {4'h0, state.chan_b_gain[11:8]};

        // output control bits
        ADDR_OUTPUT_CTRL:    next_state.rdata = {4'h0, state.chan_a_gain_enable, state.chan_b_gain_enable,
                                                 state.fixed_attenuate, state.level_detect_enable};

        // level detector value
        ADDR_LEVEL_DETECT:   next_state.rdata = state.level_detect_value;

        // channel A offset
        ADDR_CHAN_A_OFS_LO:  next_state.rdata = state.chan_a_offset[7:0];
        ADDR_CHAN_A_OFS_HI:  next_state.rdata = state.chan_a_offset[15:8];

        // channel B offset
        ADDR_CHAN_B_OFS_LO:  next_state.rdata = state.chan_b_offset[7:0];
        ADDR_CHAN_B_OFS_HI:  next_state.rdata = state.chan_b_offset[15:8];

        // input coding and source selects, reserved bits zero
        ADDR_INPUT_FORMAT:   next_state.rdata = {state.input_word_format, 3'b000,
                                                 state.i_path_source_sel, state.q_path_source_sel};

        // constant level of the I path
        ADDR_I_CONST_LO:     next_state.rdata = state.i_constant_level[7:0];
        ADDR_I_CONST_HI:     next_state.rdata = state.i_constant_level[15:8];

        // constant level of the Q path
        ADDR_Q_CONST_LO:     next_state.rdata = state.q_constant_level[7:0];
        ADDR_Q_CONST_HI:     next_state.rdata = state.q_constant_level[15:8];

        // unmapped addresses read zero
        default:             next_state.rdata = 8'h00;
      endcase
    end

    // oscillator phase accumulator, held at zero while disabled
    if (!state.osc_enable) begin
      next_state.osc_phase = '0;
    end else begin
      next_state.osc_phase = state.osc_phase + state.osc_freq_word;
    end

    // effective gain seen by the processing chain
    next_state.chan_a_gain_eff = dspcfg_gain_eff(state.chan_a_gain, state.chan_a_gain_enable);
    next_state.chan_b_gain_eff = dspcfg_gain_eff(state.chan_b_gain, state.chan_b_gain_enable);
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state                   <= '0;
      // fields whose reset value is not zero
      state.chan_a_gain_eff   <= GAIN_UNITY;
      state.chan_b_gain_eff   <= GAIN_UNITY;
      state.input_word_format <= RST_INPUT_FORMAT[INPUT_FORMAT_BIT];
      state.i_path_source_sel <= RST_INPUT_FORMAT[I_SEL_LSB+1:I_SEL_LSB];
      state.q_path_source_sel <= RST_INPUT_FORMAT[Q_SEL_LSB+1:Q_SEL_LSB];
      state.i_constant_level  <= RST_I_CONST;
      state.q_constant_level  <= RST_Q_CONST;
    end else begin
      state <= next_state;
    end
  end

  // I path source
  dspcfg_path_src u_i_path (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .source_sel     (state.i_path_source_sel),
    .ila_done       (ila_done),
    .unsigned_fmt   (state.input_word_format),
    .constant_level (state.i_constant_level),
    .lane_sample    (lane_i_sample),
    .path_sample    (i_sample)
  );

  // Q path source
  dspcfg_path_src u_q_path (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .source_sel     (state.q_path_source_sel),
    .ila_done       (ila_done),
    .unsigned_fmt   (state.input_word_format),
    .constant_level (state.q_constant_level),
    .lane_sample    (lane_q_sample),
    .path_sample    (q_sample)
  );

  // register port outputs straight from the state register
  assign reg_rdata           = state.rdata;
  assign reg_rvalid          = state.rvalid;

  // oscillator and phase correction
  assign osc_phase           = state.osc_phase;
  assign phase_fix_factor    = state.phase_fix_factor;
  assign phase_fix_enable    = state.phase_fix_enable;

  // gains, output control and detector
  assign chan_a_gain_eff     = state.chan_a_gain_eff;
  assign chan_b_gain_eff     = state.chan_b_gain_eff;
  assign fixed_attenuate     = state.fixed_attenuate;
  assign level_detect_enable = state.level_detect_enable;
  assign level_detect_value  = state.level_detect_value;

  // offsets and input coding
  assign chan_a_offset       = state.chan_a_offset;
  assign chan_b_offset       = state.chan_b_offset;
  assign input_word_format   = state.input_word_format;

endmodule // dspcfg_regs

// file: testbench/dspcfg_regs_assertions.sv
// Purpose: port-level checks on the transmit path configuration bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of dspcfg_regs
module dspcfg_regs_assertions
  import dspcfg_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // settings and oscillator
  input wire logic [39:0] osc_phase,
  input wire logic [12:0] phase_fix_factor,
  input wire logic        phase_fix_enable,
  input wire logic [11:0] chan_a_gain_eff,
  input wire logic [11:0] chan_b_gain_eff,
  input wire logic        fixed_attenuate,
  input wire logic        level_detect_enable,
  input wire logic [7:0]  level_detect_value,
  input wire logic        input_word_format
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // a write strobe aimed at one address
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  a_phase_low: assert property (s_wr(ADDR_PHASE_FIX_LOW) |=> phase_fix_factor[7:0] == $past(reg_wdata))
    else $error("phase low byte not applied");
  a_phase_high: assert property (s_wr(ADDR_PHASE_FIX_HIGH) |=>
    phase_fix_factor[12:8] == $past(reg_wdata[4:0]) && phase_fix_enable == $past(reg_wdata[7]))
    else $error("phase high byte or enable not applied");
  a_gain_a_unity: assert property (s_wr(ADDR_OUTPUT_CTRL) ##0 !reg_wdata[3] |=> ##1 chan_a_gain_eff == GAIN_UNITY)
    else $error("channel A gain not unity when disabled");
  a_gain_b_unity: assert property (s_wr(ADDR_OUTPUT_CTRL) ##0 !reg_wdata[2] |=> ##1 chan_b_gain_eff == GAIN_UNITY)
    else $error("channel B gain not unity when disabled");
  a_out_ctrl_bits: assert property (s_wr(ADDR_OUTPUT_CTRL) |=>
    fixed_attenuate == $past(reg_wdata[1]) && level_detect_enable == $past(reg_wdata[0]))
    else $error("output control bits not applied");
  a_level_value: assert property (s_wr(ADDR_LEVEL_DETECT) |=> level_detect_value == $past(reg_wdata))
    else $error("level detector value not applied");
  a_format_bit: assert property (s_wr(ADDR_INPUT_FORMAT) |=> input_word_format == $past(reg_wdata[7]))
    else $error("input format bit not applied");
  a_osc_cleared: assert property (s_wr(ADDR_TX_CONFIG) ##0 !reg_wdata[7] |=> ##1 osc_phase == 40'h00_0000_0000)
    else $error("oscillator phase not cleared when disabled");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_read_quiet: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h7a |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // dspcfg_regs_assertions

bind dspcfg_regs dspcfg_regs_assertions u_chk (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rvalid, .osc_phase, .phase_fix_factor, .phase_fix_enable, .chan_a_gain_eff, .chan_b_gain_eff,
  .fixed_attenuate, .level_detect_enable, .level_detect_value, .input_word_format);

// file: testbench/testbench.sv
// Purpose: self-checking bench for the transmit path configuration bank
// Assumes: inputs change on the falling clock edge, outputs read there
// Notes:   each scenario is a task that judges its own results
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
  import dspcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_b, reg_wr, reg_rd, ila_done, reg_rvalid, phase_fix_enable;
  logic        fixed_attenuate, level_detect_enable, input_word_format;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, level_detect_value;
  logic [15:0] lane_i_sample, lane_q_sample, i_sample, q_sample, chan_a_offset, chan_b_offset;
  logic [39:0] osc_phase;
  logic [12:0] phase_fix_factor;
  logic [11:0] chan_a_gain_eff, chan_b_gain_eff;
  int          n_mismatch = 0;
  int          n_checks = 0;

  dspcfg_regs uut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .lane_i_sample, .lane_q_sample, .ila_done, .i_sample, .q_sample, .osc_phase, .phase_fix_factor,
    .phase_fix_enable, .chan_a_gain_eff, .chan_b_gain_eff, .fixed_attenuate, .level_detect_enable,
    .level_detect_value, .chan_a_offset, .chan_b_offset, .input_word_format);

  // clock at 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // byte write: strobe for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  // byte read: data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // bits that read back; zero for unmapped places
  function automatic logic [7:0] rmask(logic [7:0] a);
    case (a)
      8'h60: return 8'h80;
      8'h61, 8'h62, 8'h63, 8'h7a: return 8'h00;
      8'h6a: return 8'h9f;
      8'h6c, 8'h6e, 8'h6f: return 8'h0f;
      8'h75: return 8'h8f;
      default: return 8'hff;
    endcase
  endfunction

  // expected sample for one path
  function automatic logic [15:0] pick(logic [1:0] s, logic il, logic f, logic [15:0] ln, logic [15:0] c);
    return (s == 2'b00 || (s == 2'b01 && il)) ? {ln[15] ^ f, ln[14:0]} : c;
  endfunction

  task automatic t_reset;
    logic [7:0] d;
    rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    rd(ADDR_INPUT_FORMAT, d);
    `CHK(d, RST_INPUT_FORMAT)
    `CHK(reg_rvalid, 1'b1)
    @(negedge core_clk);
    `CHK(reg_rvalid, 1'b0)
    rd(ADDR_I_CONST_HI, d);
    `CHK(d, RST_I_CONST[15:8])
    rd(ADDR_Q_CONST_LO, d);
    `CHK(d, RST_Q_CONST[7:0])
    `CHK(chan_a_gain_eff, GAIN_UNITY)
    `CHK(osc_phase, 40'h00_0000_0000)
    $display("test reset done");
  endtask

  task automatic t_rw;
    logic [7:0] d;
    for (int a = 8'h60; a <= 8'h7a; a++) wr(8'(a), ~8'(a));
    for (int a = 8'h60; a <= 8'h7a; a++) begin
      rd(8'(a), d);
      `CHK(d, ~8'(a) & rmask(8'(a)))
    end
    `CHK(phase_fix_factor, {5'(~8'h6a), ~8'h69})
    `CHK(phase_fix_enable, 1'b1)
    `CHK(level_detect_value, ~8'h70)
    `CHK(chan_a_offset, {~8'h72, ~8'h71})
    `CHK(chan_b_offset, {~8'h74, ~8'h73})
    `CHK(input_word_format, 1'b1)
    `CHK(chan_b_gain_eff, GAIN_UNITY)
    `CHK(fixed_attenuate, 1'b0)
    wr(ADDR_OUTPUT_CTRL, 8'h0e);
    wr(ADDR_PHASE_FIX_HIGH, 8'h1f);
    `CHK(chan_a_gain_eff, {4'(~8'h6c), ~8'h6b})
    `CHK(chan_b_gain_eff, {4'(~8'h6e), ~8'h6d})
    `CHK({fixed_attenuate, level_detect_enable, phase_fix_enable}, 3'b100)
    wr(ADDR_OUTPUT_CTRL, 8'h09);
    @(negedge core_clk);
    `CHK(chan_b_gain_eff, GAIN_UNITY)
    `CHK(chan_a_gain_eff, {4'(~8'h6c), ~8'h6b})
    `CHK({fixed_attenuate, level_detect_enable}, 2'b01)
    $display("test register access done");
  endtask

  task automatic t_osc;
    logic [39:0] f;
    f = 40'hf0_0000_0001;
    wr(ADDR_TX_CONFIG, 8'h00);
    for (int i = 0; i < 5; i++) wr(ADDR_OSC_FREQ_B0 + 8'(i), f[8*i +: 8]);
    `CHK(osc_phase, 40'h00_0000_0000)
    wr(ADDR_TX_CONFIG, 8'h80);
    `CHK(osc_phase, 40'h00_0000_0000)
    for (int i = 1; i <= 3; i++) begin
      @(negedge core_clk);
      `CHK(osc_phase, 40'(f * i))
    end
    wr(ADDR_TX_CONFIG, 8'h00);
    @(negedge core_clk);
    `CHK(osc_phase, 40'h00_0000_0000)
    $display("test oscillator done");
  endtask

  task automatic t_paths;
    wr(ADDR_I_CONST_LO, 8'h34);
    wr(ADDR_I_CONST_HI, 8'h12);
    wr(ADDR_Q_CONST_LO, 8'hcd);
    wr(ADDR_Q_CONST_HI, 8'hab);
    // k[3] format, k[2] alignment done, k[1:0] I select, Q select inverted
    for (int k = 0; k < 16; k++) begin
      lane_i_sample = 16'h4321 + 16'(k);
      lane_q_sample = 16'h8f0f - 16'(k);
      ila_done = k[2];
      wr(ADDR_INPUT_FORMAT, {k[3], 3'b000, 2'(k), ~2'(k)});
      @(negedge core_clk);
      `CHK(i_sample, pick(2'(k), k[2], k[3], lane_i_sample, 16'h1234))
      `CHK(q_sample, pick(~2'(k), k[2], k[3], lane_q_sample, 16'habcd))
    end
    $display("test sample paths done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence, second reset in mid-run at the end
  initial begin
    {reg_wr, reg_rd, ila_done} = 3'b000;
    {reg_addr, reg_wdata} = 16'h0000;
    {lane_i_sample, lane_q_sample} = 32'h0000_0000;
    t_reset();
    t_rw();
    t_osc();
    t_paths();
    t_reset();
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    #50_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // testbench
